// >>> swq_pkg.sv
// swq_pkg: constants and carrier types for the switch queue, link-change
// and source vid insertion register bank.
// assumes one 10 MHz core clock shared by every user of this package.
package swq_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SWQ_OFS_P2Q2   = 8'hb4;
    localparam logic [7:0] SWQ_OFS_P2Q1   = 8'hb5;
    localparam logic [7:0] SWQ_OFS_P2Q0   = 8'hb6;
    localparam logic [7:0] SWQ_OFS_P3Q3   = 8'hb7;
    localparam logic [7:0] SWQ_OFS_P3Q2   = 8'hb8;
    localparam logic [7:0] SWQ_OFS_P3Q1   = 8'hb9;
    localparam logic [7:0] SWQ_OFS_P3Q0   = 8'hba;
    localparam logic [7:0] SWQ_OFS_IRQEN  = 8'hbb;
    localparam logic [7:0] SWQ_OFS_LINKST = 8'hbc;
    localparam logic [7:0] SWQ_OFS_PAUSE  = 8'hbd;
    localparam logic [7:0] SWQ_OFS_FIBER  = 8'hc0;
    localparam logic [7:0] SWQ_OFS_REGUL  = 8'hc1;
    localparam logic [7:0] SWQ_OFS_VIDINS = 8'hc2;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         SWQ_SEL_BIT      = 7;
    localparam logic       SWQ_SEL_RST      = 1'b1;
    localparam logic [6:0] SWQ_Q3_LOW       = 7'h08;
    localparam logic [6:0] SWQ_Q2_LOW       = 7'h04;
    localparam logic [6:0] SWQ_Q1_LOW       = 7'h02;
    localparam logic [6:0] SWQ_Q0_LOW       = 7'h01;
    localparam int         SWQ_LS_P12_BIT   = 7;
    localparam int         SWQ_LS_P3_BIT    = 2;
    localparam int         SWQ_LS_P2_BIT    = 1;
    localparam int         SWQ_LS_P1_BIT    = 0;
    localparam logic [7:0] SWQ_LS_IMPL_MASK = 8'h87;
    localparam int         SWQ_FIB_P2_BIT   = 7;
    localparam int         SWQ_FIB_P1_BIT   = 6;
    localparam int         SWQ_REG_DIS_BIT  = 6;
    localparam int         SWQ_VID_MSB      = 5;
    localparam logic [7:0] SWQ_RST_ZERO     = 8'h00;
    localparam logic [7:0] SWQ_RD_UNMAPPED  = 8'h00;

    // ------------------------------------------------------------
    // weighted scheduling shares, four queue and two queue modes
    // ------------------------------------------------------------
    localparam logic [3:0] SWQ_W4_Q3 = 4'h8;
    localparam logic [3:0] SWQ_W4_Q2 = 4'h4;
    localparam logic [3:0] SWQ_W4_Q1 = 4'h2;
    localparam logic [3:0] SWQ_W4_Q0 = 4'h1;
    localparam logic [3:0] SWQ_W2_HI = 4'h2;
    localparam logic [3:0] SWQ_W2_LO = 4'h1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SWQ_CLK_HZ         = 10_000_000;
    localparam int SWQ_PAUSE_LIMIT_MS = 160;
    localparam int SWQ_PAUSE_CYCLES   = SWQ_PAUSE_LIMIT_MS * (SWQ_CLK_HZ / 1000);

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } swq_req_s;

    typedef struct packed {
        logic p1_copper;
        logic p1_mii;
        logic p2_copper;
        logic p3_mii;
    } swq_link_s;

    typedef struct packed {
        logic       valid;
        logic [1:0] queue;
    } swq_grant_s;

endpackage

// >>> swq_regs.sv
// swq_regs: queue scheduling, link-change status and misc control registers
// of a three port managed switch, plus the egress queue pickers of ports 2/3.
// assumes the host management interface hands over single-cycle register
// requests synchronous to the core clock.
//
// Overview of operation
// - a port whose select bits are set serves its queues 8:4:2:1 (four queues) or 2:1 (two queues).
// - with every select bit of a port at 0 and the global select at 0 the port serves the highest nonempty queue first.
// - each queue of port 2 (Q2..Q0) and port 3 (Q3..Q0) has an 8-bit register with its select bit at 7, reset 1.
// - an 8-bit enable register, reset zero, gates each link status bit onto the interrupt pin.
// - status bit 7 sets on a link change of copper port 1 or port 2.
// - status bit 2 sets on a link change of port 3 on its media independent interface.
// - status bit 1 sets on a link change of copper port 2.
// - status bit 0 sets on a link change of port 1 on copper or its media independent interface.
// - writing one to a status bit clears it, and reading leaves it set.
// - with the pause limit register nonzero, 160 ms of continuous pause requests flow control invalidation.
// - vid insert bits 5..3 tag untagged frames on paths 1 to 2, 1 to 3 and 2 to 1.
// - vid insert bits 2..0 tag untagged frames on paths 2 to 3, 3 to 1 and 3 to 2.
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// egress queue picker, one per port
// ----------------------------------------------------------------
module swq_picker (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst,
    // configuration
    input  wire logic               weighted,
    input  wire logic               two_queue,
    // queue state and dispatch request
    input  wire logic [3:0]         q_nonempty,
    input  wire logic               pick,
    // chosen queue
    output swq_pkg::swq_grant_s     grant
);
    import swq_pkg::*;

    logic [3:0]  credit_q [4];
    logic [3:0]  credit_d [4];
    swq_grant_s  grant_q;
    swq_grant_s  grant_d;
    logic [3:0]  eligible;
    logic [3:0]  weight [4];

    // two queue mode uses only q1/q0
    always_comb begin
        weight[3] = two_queue ? 4'h0 : SWQ_W4_Q3;
        weight[2] = two_queue ? 4'h0 : SWQ_W4_Q2;
        weight[1] = two_queue ? SWQ_W2_HI : SWQ_W4_Q1;
        weight[0] = two_queue ? SWQ_W2_LO : SWQ_W4_Q0;
    end

    // pick the highest eligible queue, with credit left when weighted; reload shares when the round is spent
    always_comb begin
        logic [3:0] cand;
        logic       reload;
        cand     = 4'h0;
        reload   = 1'b0;
        credit_d = credit_q;
        grant_d  = '{valid: 1'b0, queue: grant_q.queue};
        for (int i = 0; i < 4; i++) begin
            eligible[i] = q_nonempty[i] && (weight[i] != 4'h0);
            cand[i]     = eligible[i] && (credit_q[i] != 4'h0);
        end
        if (weighted && cand == 4'h0 && eligible != 4'h0) begin
            reload = 1'b1;
            cand   = eligible;
        end
        if (!weighted) begin
            cand = eligible;
        end
        if (pick && cand != 4'h0) begin
            grant_d.valid = 1'b1;
            for (int i = 0; i < 4; i++) begin
                if (cand[i]) begin
                    grant_d.queue = 2'(i);               // highest index wins
                end
            end
        end
        if (weighted && pick && grant_d.valid) begin
            for (int i = 0; i < 4; i++) begin
                credit_d[i] = reload ? weight[i] : credit_q[i];
            end
            credit_d[grant_d.queue] = credit_d[grant_d.queue] - 4'h1;
        end else if (!weighted) begin
            credit_d = weight;                           // fresh round on entry
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            credit_q <= '{default: 4'h0};
            grant_q  <= '{valid: 1'b0, queue: 2'b00};
        end else begin
            credit_q <= credit_d;
            grant_q  <= grant_d;
        end
    end

    assign grant = grant_q;

endmodule // swq_picker

// ----------------------------------------------------------------
// register bank top
// ----------------------------------------------------------------
module swq_regs #(
    parameter int PAUSE_CYCLES = swq_pkg::SWQ_PAUSE_CYCLES
) (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst,
    // host register port
    input  wire swq_pkg::swq_req_s  req,
    output logic [7:0]              rdata,
    // link state levels
    input  wire swq_pkg::swq_link_s link_up,
    // global scheduling configuration and port 2 q3 select from outside
    input  wire logic               global_sched_sel,
    input  wire logic               p2_q3_sel,
    input  wire logic               two_queue_mode,
    // egress queues
    input  wire logic [3:0]         p2_nonempty,
    input  wire logic               p2_pick,
    output swq_pkg::swq_grant_s     p2_grant,
    input  wire logic [3:0]         p3_nonempty,
    input  wire logic               p3_pick,
    output swq_pkg::swq_grant_s     p3_grant,
    // flow control
    input  wire logic               pause_active,
    output logic                    flow_ctrl_invalidate,
    // controls to the datapath and analog
    output logic [5:0]              vid_insert,
    output logic [1:0]              fiber_high_threshold,
    output logic                    core_regulator_disable,
    // interrupt
    output logic                    irq_pin_low_n
);
    import swq_pkg::*;

    localparam int CW = $clog2(PAUSE_CYCLES + 1);

    // refuse a limit the counter could never reach
    if (PAUSE_CYCLES < 1) begin : g_bad_limit
        $error("PAUSE_CYCLES must be at least one");
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [6:0]    sel_q;      // {p3q0,p3q1,p3q2,p3q3,p2q0,p2q1,p2q2}
    logic [6:0]    sel_d;
    logic [7:0]    irq_en_q;
    logic [7:0]    irq_en_d;
    logic [7:0]    link_event_flag_q;
    logic [7:0]    link_event_flag_d;
    logic [7:0]    pause_en_q;
    logic [7:0]    pause_en_d;
    logic [1:0]    fiber_q;
    logic [1:0]    fiber_d;
    logic          regul_q;
    logic          regul_d;
    logic [5:0]    vid_q;
    logic [5:0]    vid_d;
    logic [7:0]    rdata_q;
    logic [7:0]    rdata_d;
    swq_link_s     link_prev_q;
    logic [7:0]    event_set;
    logic          we;

    assign we = req.wr;

    // register writes; reserved low bits stay fixed
    always_comb begin
        sel_d    = sel_q;
        irq_en_d = irq_en_q;
        pause_en_d = pause_en_q;
        fiber_d  = fiber_q;
        regul_d  = regul_q;
        vid_d    = vid_q;
        if (we) begin
            case (req.addr)
                SWQ_OFS_P2Q2:   sel_d[0] = req.wdata[SWQ_SEL_BIT];
                SWQ_OFS_P2Q1:   sel_d[1] = req.wdata[SWQ_SEL_BIT];
                SWQ_OFS_P2Q0:   sel_d[2] = req.wdata[SWQ_SEL_BIT];
                SWQ_OFS_P3Q3:   sel_d[3] = req.wdata[SWQ_SEL_BIT];
                SWQ_OFS_P3Q2:   sel_d[4] = req.wdata[SWQ_SEL_BIT];
                SWQ_OFS_P3Q1:   sel_d[5] = req.wdata[SWQ_SEL_BIT];
                SWQ_OFS_P3Q0:   sel_d[6] = req.wdata[SWQ_SEL_BIT];
                SWQ_OFS_IRQEN:  irq_en_d = req.wdata;
                SWQ_OFS_PAUSE:  pause_en_d = req.wdata;
                SWQ_OFS_FIBER:  fiber_d = {req.wdata[SWQ_FIB_P2_BIT], req.wdata[SWQ_FIB_P1_BIT]};
                SWQ_OFS_REGUL:  regul_d = req.wdata[SWQ_REG_DIS_BIT];
                SWQ_OFS_VIDINS: vid_d = req.wdata[SWQ_VID_MSB:0];
                default:        sel_d = sel_q;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sel_q      <= {7{SWQ_SEL_RST}};
            irq_en_q   <= SWQ_RST_ZERO;
            pause_en_q <= SWQ_RST_ZERO;
            fiber_q    <= 2'b00;
            regul_q    <= 1'b0;
            vid_q      <= 6'h00;
        end else begin
            sel_q      <= sel_d;
            irq_en_q   <= irq_en_d;
            pause_en_q <= pause_en_d;
            fiber_q    <= fiber_d;
            regul_q    <= regul_d;
            vid_q      <= vid_d;
        end
    end

    // ------------------------------------------------------------
    // link change detection and write-one-to-clear status
    // ------------------------------------------------------------
    // link levels arrive synchronous; the previous sample follows even in
    // reset so no false change shows at release
    always_comb begin
        event_set                 = 8'h00;
        event_set[SWQ_LS_P12_BIT] = (link_up.p1_copper ^ link_prev_q.p1_copper)
                                  | (link_up.p2_copper ^ link_prev_q.p2_copper);
        event_set[SWQ_LS_P3_BIT]  = link_up.p3_mii ^ link_prev_q.p3_mii;
        event_set[SWQ_LS_P2_BIT]  = link_up.p2_copper ^ link_prev_q.p2_copper;
        event_set[SWQ_LS_P1_BIT]  = (link_up.p1_copper ^ link_prev_q.p1_copper)
                                  | (link_up.p1_mii ^ link_prev_q.p1_mii);
        link_event_flag_d = link_event_flag_q;
        if (we && req.addr == SWQ_OFS_LINKST) begin
            // ones clear, zeros keep; a read never touches it
            link_event_flag_d = link_event_flag_q & ~req.wdata;
        end
        // a change in the clearing cycle still lands
        link_event_flag_d = (link_event_flag_d | event_set) & SWQ_LS_IMPL_MASK;
    end

    always_ff @(posedge clock) begin
        link_prev_q <= link_up;
        if (rst) begin
            link_event_flag_q <= SWQ_RST_ZERO;
        end else begin
            link_event_flag_q <= link_event_flag_d;
        end
    end

    // interrupt held low while any enabled flag stands
    logic irq_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(link_event_flag_d & irq_en_d);
        end
    end
    assign irq_pin_low_n = ~irq_q;

    // ------------------------------------------------------------
    // pause time limit
    // ------------------------------------------------------------
    logic [CW-1:0] pause_cnt_q;
    logic [CW-1:0] pause_cnt_d;
    logic          invalidate_q;
    logic          invalidate_d;

    // counter saturates so a long pause keeps the request standing
    always_comb begin
        pause_cnt_d  = pause_cnt_q;
        invalidate_d = 1'b0;
        if (pause_en_q == SWQ_RST_ZERO || !pause_active) begin
            pause_cnt_d = '0;
        end else if (pause_cnt_q != CW'(PAUSE_CYCLES)) begin
            pause_cnt_d = pause_cnt_q + CW'(1);
        end
        if (pause_en_q != SWQ_RST_ZERO && pause_active && pause_cnt_d == CW'(PAUSE_CYCLES)) begin
            invalidate_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pause_cnt_q  <= '0;
            invalidate_q <= 1'b0;
        end else begin
            pause_cnt_q  <= pause_cnt_d;
            invalidate_q <= invalidate_d;
        end
    end
    assign flow_ctrl_invalidate = invalidate_q;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // reserved bits read their fixed defaults, unmapped reads give zero
    always_comb begin
        rdata_d = rdata_q;
        if (req.rd) begin
            case (req.addr)
                SWQ_OFS_P2Q2:   rdata_d = {sel_q[0], SWQ_Q2_LOW};
                SWQ_OFS_P2Q1:   rdata_d = {sel_q[1], SWQ_Q1_LOW};
                SWQ_OFS_P2Q0:   rdata_d = {sel_q[2], SWQ_Q0_LOW};
                SWQ_OFS_P3Q3:   rdata_d = {sel_q[3], SWQ_Q3_LOW};
                SWQ_OFS_P3Q2:   rdata_d = {sel_q[4], SWQ_Q2_LOW};
                SWQ_OFS_P3Q1:   rdata_d = {sel_q[5], SWQ_Q1_LOW};
                SWQ_OFS_P3Q0:   rdata_d = {sel_q[6], SWQ_Q0_LOW};
                SWQ_OFS_IRQEN:  rdata_d = irq_en_q;
                SWQ_OFS_LINKST: rdata_d = link_event_flag_q;
                SWQ_OFS_PAUSE:  rdata_d = pause_en_q;
                SWQ_OFS_FIBER:  rdata_d = {fiber_q, 6'h00};
                SWQ_OFS_REGUL:  rdata_d = {1'b0, regul_q, 6'h00};
                SWQ_OFS_VIDINS: rdata_d = {2'b00, vid_q};
                default:        rdata_d = SWQ_RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_q <= SWQ_RST_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign rdata = rdata_q;

    // ------------------------------------------------------------
    // outputs and queue pickers
    // ------------------------------------------------------------
    assign vid_insert             = vid_q;
    assign fiber_high_threshold   = fiber_q;
    assign core_regulator_disable = regul_q;

    // strict only when every select of the port and the global bit are 0
    logic p2_weighted;
    logic p3_weighted;
    assign p2_weighted = p2_q3_sel | (|sel_q[2:0]) | global_sched_sel;
    assign p3_weighted = (|sel_q[6:3]) | global_sched_sel;

    swq_picker u_p2_picker (
        .clock      (clock),
        .rst        (rst),
        .weighted   (p2_weighted),
        .two_queue  (two_queue_mode),
        .q_nonempty (p2_nonempty),
        .pick       (p2_pick),
        .grant      (p2_grant)
    );

    swq_picker u_p3_picker (
        .clock      (clock),
        .rst        (rst),
        .weighted   (p3_weighted),
        .two_queue  (two_queue_mode),
        .q_nonempty (p3_nonempty),
        .pick       (p3_pick),
        .grant      (p3_grant)
    );

endmodule // swq_regs

`default_nettype wire

// >>> swq_regs_checker.sv
// swq_regs_checker: port level assertions for the switch register bank.
// assumes one core clock and the synchronous active high reset of swq_regs.
`timescale 1ns/100ps
`default_nettype none
module swq_regs_checker #(
    parameter int PAUSE_CYCLES = swq_pkg::SWQ_PAUSE_CYCLES
) (
    // clock and reset
    input wire logic                clock,
    input wire logic                rst,
    // host and link inputs
    input wire swq_pkg::swq_req_s   req,
    input wire swq_pkg::swq_link_s  link_up,
    input wire logic                two_queue_mode,
    input wire logic                pause_active,
    // queue pickers
    input wire logic [3:0]          p2_nonempty,
    input wire logic                p2_pick,
    input wire swq_pkg::swq_grant_s p2_grant,
    input wire logic                p3_pick,
    input wire swq_pkg::swq_grant_s p3_grant,
    // outputs under watch
    input wire logic                flow_ctrl_invalidate,
    input wire logic [5:0]          vid_insert,
    input wire logic                irq_pin_low_n
);
    import swq_pkg::*;
    // ----------------------------------------------------------------
    // pause run length, the limit is only legal after a full run
    // ----------------------------------------------------------------
    logic [31:0] pause_run_q;
    logic [31:0] pause_run_d;
    always_comb begin
        pause_run_d = pause_active ? pause_run_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge clock) begin
        pause_run_q <= rst ? 32'h0 : pause_run_d;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    p2_answer_a: assert property (p2_grant.valid |-> $past(p2_pick))
        else $error("port 2 grant without a pick");
    p3_answer_a: assert property (p3_grant.valid |-> $past(p3_pick))
        else $error("port 3 grant without a pick");
    p2_eligible_a: assert property (p2_grant.valid |-> (($past(p2_nonempty) >> p2_grant.queue) & 4'h1) != 4'h0)
        else $error("port 2 granted an empty queue");
    two_queue_a: assert property (p3_grant.valid && $past(two_queue_mode) |-> !p3_grant.queue[1])
        else $error("two queue mode granted a high queue");
    pause_drop_a: assert property (!pause_active |=> !flow_ctrl_invalidate)
        else $error("invalidate held without pause");
    pause_wait_a: assert property ($rose(flow_ctrl_invalidate) |-> pause_run_q >= PAUSE_CYCLES)
        else $error("invalidate before full pause run");
    irq_cause_a: assert property ($fell(irq_pin_low_n) |-> $past(link_up) != $past(link_up, 2) || $past(req.wr))
        else $error("interrupt without link change or write");
    irq_release_a: assert property ($rose(irq_pin_low_n) |-> $past(req.wr))
        else $error("interrupt released without a write");
    reset_quiet_a: assert property ($fell(rst) |-> irq_pin_low_n && !flow_ctrl_invalidate && vid_insert == 6'h00)
        else $error("outputs not at reset values");
    cover property ($fell(irq_pin_low_n));
    cover property ($rose(flow_ctrl_invalidate));
    cover property (p2_grant.valid && p2_grant.queue == 2'h3);
endmodule // swq_regs_checker
bind swq_regs swq_regs_checker #(.PAUSE_CYCLES(PAUSE_CYCLES)) u_chk (.clock(clock), .rst(rst), .req(req),
    .link_up(link_up), .two_queue_mode(two_queue_mode), .pause_active(pause_active), .p2_nonempty(p2_nonempty),
    .p2_pick(p2_pick), .p2_grant(p2_grant), .p3_pick(p3_pick), .p3_grant(p3_grant),
    .flow_ctrl_invalidate(flow_ctrl_invalidate), .vid_insert(vid_insert), .irq_pin_low_n(irq_pin_low_n));
`default_nettype wire

// >>> swq_regs_bench.sv
// swq_regs_bench: self checking bench for swq_regs against a register model.
// assumes swq_pkg and swq_regs are compiled first; shortened pause count.
`timescale 1ns/100ps
`default_nettype none
module swq_regs_bench;
    import swq_pkg::*;
    // ----------------------------------------------------------------
    // signals and model state
    // ----------------------------------------------------------------
    localparam int         PC = 20;
    localparam logic [7:0] QRST [7] = '{8'h84, 8'h82, 8'h81, 8'h88, 8'h84, 8'h82, 8'h81};
    localparam logic [7:0] EVT [4]  = '{8'h04, 8'h82, 8'h01, 8'h81};
    logic       clock, rst, gsel, p2q3, twoq, p2_pick, p3_pick, pause, inv, reg_dis, irq_n;
    logic [7:0] rdata, d;
    logic [5:0] vid;
    logic [1:0] fib;
    logic [3:0] p2_ne, p3_ne, nev;
    swq_req_s   req;
    swq_link_s  link_up;
    swq_grant_s p2_grant, p3_grant;
    logic [1:0] g2 [$], g3 [$], want [$];
    logic [7:0] mdl [256];
    int         n_mismatch, tests_run, seed, n;
    swq_regs #(.PAUSE_CYCLES(PC)) u_dut (.clock(clock), .rst(rst), .req(req), .rdata(rdata), .link_up(link_up),
        .global_sched_sel(gsel), .p2_q3_sel(p2q3), .two_queue_mode(twoq), .p2_nonempty(p2_ne), .p2_pick(p2_pick),
        .p2_grant(p2_grant), .p3_nonempty(p3_ne), .p3_pick(p3_pick), .p3_grant(p3_grant), .pause_active(pause),
        .flow_ctrl_invalidate(inv), .vid_insert(vid), .fiber_high_threshold(fib),
        .core_regulator_disable(reg_dis), .irq_pin_low_n(irq_n));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp_v);
        tests_run++;
        if (seen !== exp_v) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp_v);
        end
    endtask
    // write, then apply the same write to the model by access kind
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock); #1;
        req = '{wr:1'b1, rd:1'b0, addr:a, wdata:v};
        @(posedge clock); #1;
        req.wr = 1'b0;
        if (a >= SWQ_OFS_P2Q2 && a <= SWQ_OFS_P3Q0) mdl[a][7] = v[7];
        else if (a == SWQ_OFS_IRQEN || a == SWQ_OFS_PAUSE) mdl[a] = v;
        else if (a == SWQ_OFS_LINKST) mdl[a] = mdl[a] & ~v;
        else if (a == SWQ_OFS_FIBER) mdl[a] = v & 8'hc0;
        else if (a == SWQ_OFS_REGUL) mdl[a] = v & 8'h40;
        else if (a == SWQ_OFS_VIDINS) mdl[a] = v & 8'h3f;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock); #1;
        req.rd = 1'b1;
        req.addr = a;
        @(posedge clock); #1;
        req.rd = 1'b0;
        check(rdata, mdl[a]);
    endtask
    // toggle one link level; the interrupt pin follows status and enable
    task automatic flip(input int b);
        @(posedge clock); #1;
        link_up[b] = ~link_up[b];
        mdl[SWQ_OFS_LINKST] = mdl[SWQ_OFS_LINKST] | EVT[b];
        rd(SWQ_OFS_LINKST);
        check({7'h0, irq_n}, {7'h0, ~|(mdl[SWQ_OFS_LINKST] & mdl[SWQ_OFS_IRQEN])});
    endtask
    // consecutive picks on both ports, grants gathered in order
    task automatic serve(input int cnt, input logic [3:0] ne);
        g2.delete();
        g3.delete();
        p2_ne = ne;
        p3_ne = ne;
        for (int i = 0; i < cnt + 2; i++) begin
            p2_pick = (i < cnt);
            p3_pick = (i < cnt);
            @(posedge clock); #1;
            if (p2_grant.valid === 1'b1) g2.push_back(p2_grant.queue);
            if (p3_grant.valid === 1'b1) g3.push_back(p3_grant.queue);
        end
        check(8'(g2.size()), 8'(want.size()));
        check(8'(g3.size()), 8'(want.size()));
        foreach (want[i]) begin
            check({6'h0, g2[i]}, {6'h0, want[i]});
            check({6'h0, g3[i]}, {6'h0, want[i]});
        end
    endtask
    task automatic weighted_round;
        want.delete();
        for (int q = 3; q >= 0; q--) repeat (1 << q) want.push_back(2'(q));
        serve(15, 4'hf);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        repeat (6000) @(posedge clock);
        n_mismatch++;
        conclude();
    end
    initial begin
        {rst, gsel, p2q3, twoq, p2_pick, p3_pick, pause} = 7'h50;
        {req, link_up, p2_ne, p3_ne} = '0;
        n_mismatch = 0;
        tests_run = 0;
        seed = 32'h7dd2a1c8;
        foreach (mdl[i]) mdl[i] = 8'h00;
        foreach (QRST[i]) mdl[8'(8'hb4 + i)] = QRST[i];
        repeat (6) @(posedge clock);
        #1 rst = 1'b0;
        // reset values, unmapped offsets included, then random writes
        for (int a = 8'hb4; a <= 8'hc3; a++) rd(8'(a));
        for (int a = 8'hb4; a <= 8'hc3; a++) begin
            d = 8'($random(seed));
            wr(8'(a), d);
            rd(8'(a));
        end
        check({2'h0, vid}, mdl[SWQ_OFS_VIDINS]);
        check({6'h0, fib}, {6'h0, mdl[SWQ_OFS_FIBER][7:6]});
        check({7'h0, reg_dis}, {7'h0, mdl[SWQ_OFS_REGUL][6]});
        // weighted then strict scheduling
        foreach (QRST[i]) wr(8'(8'hb4 + i), QRST[i]);
        weighted_round();
        twoq = 1'b1;
        want = '{2'h1, 2'h1, 2'h0};
        serve(3, 4'hf);
        want.delete();
        serve(2, 4'hc);
        twoq = 1'b0;
        foreach (QRST[i]) wr(8'(8'hb4 + i), {1'b0, QRST[i][6:0]});
        p2q3 = 1'b0;
        for (int k = 0; k < 10; k++) begin
            nev = 4'($random(seed));
            want.delete();
            for (int q = 3; q >= 0; q--) if (nev[q] && want.size() == 0) want.push_back(2'(q));
            serve(1, nev);
        end
        gsel = 1'b1;
        weighted_round();
        // link change flags, enable and write one to clear
        wr(SWQ_OFS_IRQEN, 8'h00);
        wr(SWQ_OFS_LINKST, 8'hff);
        flip(1);
        wr(SWQ_OFS_IRQEN, 8'h02);
        flip(1);
        wr(SWQ_OFS_LINKST, 8'h00);
        flip(0);
        wr(SWQ_OFS_LINKST, 8'h02);
        rd(SWQ_OFS_LINKST);
        check({7'h0, irq_n}, 8'h01);
        wr(SWQ_OFS_IRQEN, 8'hff);
        for (int b = 0; b < 4; b++) begin
            wr(SWQ_OFS_LINKST, 8'hff);
            flip(b);
        end
        // pause limit, enabled then disabled
        wr(SWQ_OFS_PAUSE, 8'h01);
        pause = 1'b1;
        n = 0;
        do begin
            @(posedge clock); #1;
            n++;
        end while (inv !== 1'b1 && n < 200);
        check(8'(n), 8'(PC));
        pause = 1'b0;
        repeat (2) @(posedge clock);
        #1 check({7'h0, inv}, 8'h00);
        wr(SWQ_OFS_PAUSE, 8'h00);
        pause = 1'b1;
        repeat (PC + 5) @(posedge clock);
        #1 check({7'h0, inv}, 8'h00);
        pause = 1'b0;
        conclude();
    end
endmodule // swq_regs_bench
`default_nettype wire
